// ---- tmc_timer.sv ----
// module: 8-bit period timer with mode-controlled start, reset and stop
// How it works
// R1: mode[4:3] picks free-run, one-shot, monostable/level-start or reserved; reserved codes stay idle.
// R2: partner leaves six timer clocks between trigger edges in edge modes.
// R3: partner holds a trigger level at least three timer clocks in level modes.
// R4: in debug mode the external trigger/reset input is ignored.
// R5: free-run 000 counts while enable is one, halts while zero, pulses period.
// R6: free-run 001/010 count only when enabled and trigger high/low.
// R7: free-run 011/100/101 run on enable, reset on any/rising/falling edge.
// R8: free-run 110/111 held reset while trigger low/high, else run when enabled.
// R9: one-shot 000 starts as soon as enable is set.
// R10: one-shot 001/010/011 start on rising/falling/any edge while enabled.
// R11: one-shot 100/101 start on rising/falling edge, later same edges reset count.
// R12: one-shot 110 rise start, low reset; 111 fall start, high reset.
// R13: one-shot: clock after match clears enable, counter stops at zero.
// R14: edge-start modes need a fresh edge after enable returns to one.
// R15: monostable 001/010/011 start on rising/falling/any edge; 000 reserved.
// R16: monostable: clock after match stops at zero but keeps enable set.
// R17: level start 110 high start low reset; 111 low start high reset.
// R18: counter increments per timer clock; at match it pulses and clears next clock.
// R19: external trigger is synchronised to the timer clock before detection.
`timescale 1ns/10ps
module tmc_timer
  import tmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [TMC_MODE_W-1:0] i_mode,
  input wire logic [7:0] i_presc_div,
  input wire logic i_debug,
  input wire logic i_ext_reset_trigger,
  output logic o_period_pulse,
  output logic o_on
);
  typedef enum logic [2:0] {
    TMC_IDLE = 3'b001,
    TMC_ARMED = 3'b010,
    TMC_RUN = 3'b100
  } tmc_state_e;

  tmc_state_e state_reg;
  tmc_state_e state_next;
  logic on_reg;
  logic on_next;
  logic [7:0] period_value_reg;
  logic [7:0] count_value_reg;
  logic [7:0] count_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic pulse_reg;
  logic tick;
  tmc_trig_if trig ();

  // ----------------------------------------
  // timer clock and trigger conditioning
  // ----------------------------------------
  tmc_presc u_presc (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_div(i_presc_div),
    .o_tick(tick)
  );

  tmc_trig_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_tick(tick),
    .i_ext_reset_trigger(i_ext_reset_trigger),
    .trig(trig)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire [1:0] cls = i_mode[TMC_CLASS_HI:TMC_CLASS_LO];
  wire [2:0] sub = i_mode[TMC_SUB_HI:TMC_SUB_LO];
  // debug masks every trigger event and forces the idle level
  wire ext_lvl = trig.level & ~i_debug; // R4
  wire ext_rise = trig.rise & ~i_debug; // R4
  wire ext_fall = trig.fall & ~i_debug; // R4
  wire ext_any = ext_rise | ext_fall;
  wire is_free = (cls == TMC_CLS_FREE); // R1
  wire is_os = (cls == TMC_CLS_ONESHOT); // R1
  wire is_mono = (cls == TMC_CLS_MONO) && (sub >= TMC_SUB_1) && (sub <= TMC_SUB_3); // R15
  wire is_lvl = (cls == TMC_CLS_MONO) && (sub >= TMC_SUB_6); // R17
  wire valid = is_free | is_os | is_mono | is_lvl; // R1
  wire oneshot = is_os | is_lvl;
  wire sub_is3 = (sub == TMC_SUB_3);
  wire sub_rise = (sub == TMC_SUB_1) | (sub == TMC_SUB_4) | (sub == TMC_SUB_6);

  // start condition for the armed state
  wire edge_start = sub_is3 ? ext_any : (sub_rise ? ext_rise : ext_fall); // R10 R15
  wire start_os = (sub == TMC_SUB_0) ? 1'b1 : edge_start; // R9 R10 R11 R12
  wire start_lvl = (sub == TMC_SUB_6) ? ext_lvl : ~ext_lvl; // R17
  wire start_cond = is_lvl ? start_lvl : (is_mono ? edge_start : start_os);

  // gating in the free-run class
  wire gate_ok = (sub == TMC_SUB_1) ? ext_lvl : ((sub == TMC_SUB_2) ? ~ext_lvl : 1'b1); // R6
  wire lvl_hold_free = ((sub == TMC_SUB_6) & ~ext_lvl) | ((sub == TMC_SUB_7) & ext_lvl); // R8

  // count reset while running
  wire edge_rst_free = ((sub == TMC_SUB_3) & ext_any) | ((sub == TMC_SUB_4) & ext_rise)
                     | ((sub == TMC_SUB_5) & ext_fall); // R7
  wire edge_rst_os = ((sub == TMC_SUB_4) & ext_rise) | ((sub == TMC_SUB_5) & ext_fall); // R11
  wire lvl_rst_os = ((sub == TMC_SUB_6) & ~ext_lvl) | ((sub == TMC_SUB_7) & ext_lvl); // R12 R17
  wire cnt_reset = is_free ? (edge_rst_free | lvl_hold_free) : (is_os ? (edge_rst_os | lvl_rst_os)
                 : (is_lvl ? lvl_rst_os : 1'b0));
  wire hold_run = is_free ? (gate_ok & ~lvl_hold_free) : ~(is_os & lvl_rst_os) & ~(is_lvl & lvl_rst_os);
  // a gated or held counter must not wrap on a stale match either
  wire advance = hold_run & ~cnt_reset; // R6 R8

  wire match = (count_value_reg == period_value_reg); // R18
  wire sw_wr_ctrl = i_wr && (i_addr == TMC_ADDR_CTRL);
  wire sw_on = sw_wr_ctrl ? i_wdata[TMC_CTRL_ON_BIT] : on_reg;
  wire running = (state_reg == TMC_RUN);

  // ----------------------------------------
  // control state and counter
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    on_next = sw_on;
    count_next = count_value_reg;
    if (!sw_on || !valid) begin
      // dropping enable forces a fresh start condition later
      state_next = TMC_IDLE; // R14
    end else if (tick) begin
      unique case (state_reg)
        TMC_IDLE: begin
          if (is_free) begin
            state_next = TMC_RUN; // R5 R7
          end else begin
            state_next = TMC_ARMED; // R14
          end
        end
        TMC_ARMED: begin
          if (start_cond) begin
            // count is kept, so a re-enabled timer resumes where it stopped
            state_next = TMC_RUN; // R9 R10 R14 R15 R17
          end
        end
        TMC_RUN: begin
          if (cnt_reset) begin
            count_next = 8'h00; // R7 R8 R11 R12
          end else if (hold_run) begin
            if (match) begin
              count_next = 8'h00; // R18
              if (oneshot) begin
                on_next = 1'b0; // R13
                state_next = TMC_IDLE; // R13
              end else if (is_mono) begin
                state_next = TMC_ARMED; // R16
              end
            end else begin
              count_next = count_value_reg + 8'h01; // R5 R6 R18
            end
          end
        end
        default: begin
          state_next = TMC_IDLE;
        end
      endcase
    end
    if (i_wr && (i_addr == TMC_ADDR_COUNT)) begin
      count_next = i_wdata;
    end
  end

  // ----------------------------------------
  // register port read decode
  // ----------------------------------------
  always_comb begin
    unique case (i_addr)
      TMC_ADDR_CTRL: rdata_next = {on_reg, 7'h00};
      TMC_ADDR_PERIOD: rdata_next = period_value_reg;
      TMC_ADDR_COUNT: rdata_next = count_value_reg;
      TMC_ADDR_STATUS: rdata_next = {5'h00, ~valid, state_reg == TMC_ARMED, running};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= TMC_IDLE;
      on_reg <= 1'b0;
      count_value_reg <= TMC_COUNT_RST;
      period_value_reg <= TMC_PERIOD_RST;
      pulse_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      on_reg <= on_next;
      count_value_reg <= count_next;
      pulse_reg <= tick & running & sw_on & valid & match & advance; // R5 R18
      if (i_wr && (i_addr == TMC_ADDR_PERIOD)) begin
        period_value_reg <= i_wdata;
      end
      rdata_reg <= i_rd ? rdata_next : 8'h00;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_period_pulse = pulse_reg;
  assign o_on = on_reg;
endmodule

// ---- tmc_pkg.sv ----
// package: mode codes, field positions, reset values and timing counts for the timer mode control
package tmc_pkg;
  localparam int TMC_MODE_W = 5;
  localparam int TMC_CNT_W = 8;
  localparam int TMC_CLASS_HI = 4;
  localparam int TMC_CLASS_LO = 3;
  localparam int TMC_SUB_HI = 2;
  localparam int TMC_SUB_LO = 0;
  localparam logic [1:0] TMC_CLS_FREE = 2'h0;
  localparam logic [1:0] TMC_CLS_ONESHOT = 2'h1;
  localparam logic [1:0] TMC_CLS_MONO = 2'h2;
  localparam logic [1:0] TMC_CLS_RSVD = 2'h3;
  localparam logic [2:0] TMC_SUB_0 = 3'h0;
  localparam logic [2:0] TMC_SUB_1 = 3'h1;
  localparam logic [2:0] TMC_SUB_2 = 3'h2;
  localparam logic [2:0] TMC_SUB_3 = 3'h3;
  localparam logic [2:0] TMC_SUB_4 = 3'h4;
  localparam logic [2:0] TMC_SUB_5 = 3'h5;
  localparam logic [2:0] TMC_SUB_6 = 3'h6;
  localparam logic [2:0] TMC_SUB_7 = 3'h7;
  // register indices of the plain register port
  localparam logic [1:0] TMC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] TMC_ADDR_PERIOD = 2'h1;
  localparam logic [1:0] TMC_ADDR_COUNT = 2'h2;
  localparam logic [1:0] TMC_ADDR_STATUS = 2'h3;
  localparam int TMC_CTRL_ON_BIT = 7;
  localparam int TMC_STAT_RUN_BIT = 0;
  localparam int TMC_STAT_ARMED_BIT = 1;
  localparam int TMC_STAT_RSVD_BIT = 2;
  localparam logic [7:0] TMC_CTRL_RST = 8'h00;
  localparam logic [7:0] TMC_PERIOD_RST = 8'hff;
  localparam logic [7:0] TMC_COUNT_RST = 8'h00;
  localparam logic [7:0] TMC_PRESC_RST = 8'h00;
  // partner spacing figures, in timer clock periods
  localparam int TMC_EDGE_GAP_TCLK = 6;
  localparam int TMC_LEVEL_MIN_TCLK = 3;
endpackage

// ---- tmc_trig_if.sv ----
// interface: conditioned trigger level and edge pulses between synchroniser and controller
`timescale 1ns/10ps
interface tmc_trig_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ---- tmc_trig_sync.sv ----
// module: synchroniser and edge detector for the external reset/trigger input
`timescale 1ns/10ps
module tmc_trig_sync
  import tmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_tick,
  input wire logic i_ext_reset_trigger,
  tmc_trig_if.src trig
);
  logic s1_reg;
  logic s2_reg;
  logic lvl_reg;
  logic prev_reg;

  // ----------------------------------------
  // two-stage sync, then sample on timer ticks
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      lvl_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      s1_reg <= i_ext_reset_trigger; // R19
      s2_reg <= s1_reg; // R19
      if (i_tick) begin
        prev_reg <= lvl_reg;
        lvl_reg <= s2_reg; // R19
      end
    end
  end

  // edges are judged between two timer clock samples
  assign trig.level = lvl_reg;
  assign trig.rise = i_tick & lvl_reg & ~prev_reg;
  assign trig.fall = i_tick & ~lvl_reg & prev_reg;
endmodule

// ---- tmc_presc.sv ----
// module: divider giving the one-cycle timer clock enable
`timescale 1ns/10ps
module tmc_presc
  import tmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_div,
  output logic o_tick
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic wrap;

  // ----------------------------------------
  // tick every (i_div + 1) reference cycles
  // ----------------------------------------
  assign wrap = (cnt_reg >= i_div);
  assign cnt_next = wrap ? 8'h00 : cnt_reg + 8'h01;
  assign o_tick = wrap;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= TMC_PRESC_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ---- tmc_timer_props.sv ----
// checker: timing relations at the timer ports
`timescale 1ns/10ps
module tmc_timer_props
  import tmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [TMC_MODE_W-1:0] i_mode,
  input wire logic [7:0] i_presc_div,
  input wire logic i_debug,
  input wire logic i_ext_reset_trigger,
  input wire logic o_period_pulse,
  input wire logic o_on
);
  // ----
  // properties
  // ----
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  wire logic [1:0] cls = i_mode[TMC_CLASS_HI:TMC_CLASS_LO];
  wire logic trig_off = !i_debug && !i_ext_reset_trigger;
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_rsvd_idle: assert property ((cls == TMC_CLS_RSVD) [*3] |=> !o_period_pulse)
    else $error("pulse in reserved mode");
  chk_shot_off: assert property ($past(cls == TMC_CLS_ONESHOT) && o_period_pulse |-> !o_on)
    else $error("one-shot kept enable after match");
  chk_mono_on: assert property ($past(cls == TMC_CLS_MONO && i_mode[2:1] != 2'h3 && o_on && !i_wr)
    && o_period_pulse |-> o_on)
    else $error("monostable lost enable");
  chk_pulse_on: assert property (o_period_pulse |-> $past(o_on) || $past(o_on, 2))
    else $error("pulse while disabled");
  chk_gate_low: assert property ((i_mode == 5'h01 && trig_off) [*6] |-> !o_period_pulse)
    else $error("gate low still counting");
  chk_level_hold: assert property ((i_mode == 5'h06 && trig_off) [*6] |-> !o_period_pulse)
    else $error("held timer pulsed");
  chk_on_by_sw: assert property ($rose(o_on) |->
    $past(i_wr && i_addr == TMC_ADDR_CTRL && i_wdata[TMC_CTRL_ON_BIT]))
    else $error("enable set without write");
  cover property (cls == TMC_CLS_ONESHOT && o_period_pulse);
  cover property (cls == TMC_CLS_MONO && o_period_pulse);
  cover property ($fell(o_on));
endmodule
bind tmc_timer tmc_timer_props u_tmc_timer_props (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_mode, .i_presc_div, .i_debug, .i_ext_reset_trigger, .o_period_pulse, .o_on);

// ---- tmc_trig_src.sv ----
// partner: external reset/trigger source
`timescale 1ns/10ps
module tmc_trig_src
  import tmc_pkg::*;
(
  input wire logic i_ref_clk,
  output logic o_trig
);
  // spacing counted in ref cycles, exact only while the divider is 0
  int cyc = 0;
  int last = 0;
  initial o_trig = 1'b0;
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  task automatic drive(input logic v);
    while (cyc - last < TMC_EDGE_GAP_TCLK) @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    o_trig <= v;
    last = cyc;
  endtask
endmodule

// ---- timer_mode_control_hlt_tb_top.sv ----
// testbench: mode control scenarios for the timer
`timescale 1ns/10ps
module timer_mode_control_hlt_tb_top
  import tmc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dbg = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] div = 8'h00;
  logic [TMC_MODE_W-1:0] mode = 5'h00;
  logic [7:0] rdata;
  logic pulse;
  logic on;
  wire trig;
  int mismatches = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  // divider left at 0 outside the slow-clock check, so partner spacing in ref cycles holds
  tmc_timer u_tmc_timer (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_mode(mode), .i_presc_div(div), .i_debug(dbg),
    .i_ext_reset_trigger(trig), .o_period_pulse(pulse), .o_on(on));
  tmc_trig_src u_tmc_trig_src (.i_ref_clk(clk), .o_trig(trig));
  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (pulse !== 1'b1 && n < 300);
  endtask
  task automatic setup(input logic [TMC_MODE_W-1:0] m, input logic [7:0] p);
    wr_reg(TMC_ADDR_CTRL, 8'h00);
    mode <= m;
    wr_reg(TMC_ADDR_PERIOD, p);
    wr_reg(TMC_ADDR_COUNT, 8'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_free;
    logic [7:0] v;
    logic [7:0] v2;
    int n;
    rd_reg(TMC_ADDR_PERIOD, v);
    chk("period reset", 8'hff, v);
    setup(5'h00, 8'h04);
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    wait_pulse(n);
    wait_pulse(n);
    chk("pulse spacing", 8'h05, n[7:0]);
    div <= 8'h01;
    wait_pulse(n);
    wait_pulse(n);
    chk("slow pulse spacing", 8'h0a, n[7:0]);
    div <= 8'h00;
    wr_reg(TMC_ADDR_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    repeat (10) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v2);
    chk("halted count", v, v2);
    $display("done free");
  endtask
  task automatic t_shot;
    logic [7:0] v;
    int n;
    setup(5'h08, 8'h06);
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    wait_pulse(n);
    chk("soft start", 8'h01, {7'h00, n < 300});
    chk("enable after end", 8'h00, {7'h00, on});
    repeat (10) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("stopped count", 8'h00, v);
    $display("done shot");
  endtask
  task automatic t_edge;
    logic [7:0] v;
    int n;
    setup(5'h09, 8'h06);
    dbg <= 1'b1;
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    u_tmc_trig_src.drive(1'b1);
    repeat (20) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("debug count", 8'h00, v);
    chk("debug enable", 8'h01, {7'h00, on});
    u_tmc_trig_src.drive(1'b0);
    dbg <= 1'b0;
    repeat (10) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("waiting count", 8'h00, v);
    u_tmc_trig_src.drive(1'b1);
    wait_pulse(n);
    chk("edge start", 8'h01, {7'h00, n < 300});
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    repeat (20) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("no fresh edge", 8'h00, v);
    chk("fresh edge enable", 8'h01, {7'h00, on});
    u_tmc_trig_src.drive(1'b0);
    $display("done edge");
  endtask
  task automatic t_mono;
    int n;
    setup(5'h11, 8'h06);
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    u_tmc_trig_src.drive(1'b1);
    wait_pulse(n);
    chk("mono start", 8'h01, {7'h00, n < 300});
    chk("mono enable", 8'h01, {7'h00, on});
    u_tmc_trig_src.drive(1'b0);
    u_tmc_trig_src.drive(1'b1);
    wait_pulse(n);
    chk("mono restart", 8'h01, {7'h00, n < 300});
    u_tmc_trig_src.drive(1'b0);
    $display("done mono");
  endtask
  task automatic t_level;
    logic [7:0] v;
    logic [TMC_MODE_W-1:0] ms[4] = '{5'h18, 5'h10, 5'h01, 5'h06};
    for (int i = 0; i < 4; i++) begin
      setup(ms[i], 8'h40);
      wr_reg(TMC_ADDR_CTRL, 8'h80);
      repeat (20) @(posedge clk);
      rd_reg(TMC_ADDR_COUNT, v);
      chk("blocked count", 8'h00, v);
      u_tmc_trig_src.drive(1'b1);
      repeat (20) @(posedge clk);
      rd_reg(TMC_ADDR_COUNT, v);
      chk("running", {7'h00, i > 1}, {7'h00, v != 8'h00});
      rd_reg(TMC_ADDR_STATUS, v);
      chk("status", {5'h00, i < 2, 1'b0, i > 1}, v);
      u_tmc_trig_src.drive(1'b0);
    end
    $display("done level");
  endtask
  task automatic t_hlt;
    logic [7:0] v;
    setup(5'h04, 8'h40);
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    repeat (20) @(posedge clk);
    u_tmc_trig_src.drive(1'b1);
    repeat (4) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("free edge reset", 8'h01, {7'h00, v < 8'h08});
    u_tmc_trig_src.drive(1'b0);
    setup(5'h0c, 8'h40);
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    repeat (10) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("shot waits edge", 8'h00, v);
    u_tmc_trig_src.drive(1'b1);
    repeat (20) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("shot edge start", 8'h01, {7'h00, v > 8'h08});
    u_tmc_trig_src.drive(1'b0);
    u_tmc_trig_src.drive(1'b1);
    repeat (4) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("shot edge reset", 8'h01, {7'h00, v < 8'h08});
    u_tmc_trig_src.drive(1'b0);
    setup(5'h16, 8'h40);
    wr_reg(TMC_ADDR_CTRL, 8'h80);
    repeat (10) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("level waits", 8'h00, v);
    u_tmc_trig_src.drive(1'b1);
    repeat (20) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("level start", 8'h01, {7'h00, v > 8'h08});
    u_tmc_trig_src.drive(1'b0);
    repeat (10) @(posedge clk);
    rd_reg(TMC_ADDR_COUNT, v);
    chk("level reset", 8'h00, v);
    $display("done hlt");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_free();
    t_shot();
    t_edge();
    t_mono();
    t_level();
    t_hlt();
    print_verdict();
  end
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule
